// [pkg/dbr_pkg.sv]
// Shared types and constants of the DRAM bank decode and refresh block.
// Assumes one 200 MHz clock that is the processor bus clock.
package dbr_pkg;
  // ==========================================================
  // Clock and timing
  localparam int CLK_PS = 5000;           // Clock period in ps
  localparam int REF_NS = 9600;           // Refresh interval in ns
  localparam int RAS_MAX_NS = 10000;      // Longest row strobe low in ns
  localparam int RCD_NS = 20;             // Row to column delay in ns
  localparam int CAS_NS = 40;             // Column strobe width in ns
  localparam int RP_NS = 60;              // Row precharge in ns
  localparam int CSR_NS = 10;             // Column before row setup in ns
  localparam int RAS_REF_NS = 80;         // Row strobe width in refresh in ns
  // Least times round up, longest times round down
  localparam int REF_CYC = (REF_NS * 1000) / CLK_PS;
  localparam int RAS_MAX_CYC = (RAS_MAX_NS * 1000) / CLK_PS;
  localparam int RCD_CYC = (RCD_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CAS_CYC = (CAS_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int RP_CYC = (RP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CSR_CYC = (CSR_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int RAS_REF_CYC = (RAS_REF_NS * 1000 + CLK_PS - 1) / CLK_PS;
  // ==========================================================
  // Address layout
  localparam int REGION_LSB = 22;         // Bits at and above are zero in DRAM
  localparam int BANK_LSB = 20;           // Bank select field low bit
  localparam int ROW_LSB = 11;            // Row field low bit
  localparam int COL_LSB = 2;             // Column field low bit
  localparam int MA_W = 9;                // Memory address width
  localparam int NBANK = 4;               // Banks and byte lanes
  localparam logic [3:0] STROBES_OFF = 4'hF; // All strobes released
  // ==========================================================
  // Bus request from the processor side
  typedef struct packed {
    logic ale;                            // Address phase marker
    logic rd;                             // Read strobe
    logic wr;                             // Write strobe
    logic [3:0] be;                       // Byte enables
  } dbr_bus_t;
  // Pins toward the memory array, all active low but the address
  typedef struct packed {
    logic [3:0] row_n;                    // Row strobes per bank
    logic [3:0] col_n;                    // Column strobes per lane
    logic [3:0] we_n;                     // Write enables per bank
    logic [MA_W-1:0] ma;                  // Multiplexed address
  } dbr_mem_t;
  // Controller states
  typedef enum logic [3:0] {
    S_REF_COL = 4'h0,
    S_REF_ROW = 4'h1,
    S_PRE = 4'h2,
    S_IDLE = 4'h3,
    S_ROW = 4'h4,
    S_COL = 4'h5,
    S_OPEN = 4'h6
  } dbr_state_t;
endpackage

// [verilog/dbr_ctrl.sv]
// DRAM bank decode, strobe generation and refresh for a four bank array.
// Assumes bus strobes are synchronous to clk_i and held until ack_o.
`timescale 1ns/1ps
// Notes on behaviour
// - Respond only inside bottom 4MB region
// - Address bits 21:20 pick the bank
// - Read or write strobe chooses access type
// - One row strobe per bank, same number
// - One write enable per bank, same number
// - Exactly one bank active per access
// - Each bank is one contiguous 1MB
// - Reads full word, writes enabled lanes only
// - Column strobe n follows byte enable n
// - Column strobes shared by all banks
// - Refresh request every 9.6 microseconds
// - Timer counts clock or external oscillator
// - Row strobe never low past 10 microseconds
// - Refresh through row and column strobes
// - All logic on processor bus clock
// - Latch address phase of multiplexed bus
// - Memory address muxes row then column
// - Refresh wins, but never splits cycles
// - Acknowledge holds timer; column before row
// - One refresh after reset before idle
module dbr_ctrl #(
  parameter bit USE_OSC = 1'b0,           // Timer counts osc_tick_i when set
  parameter int OSC_REF_TICKS = 96        // Oscillator ticks per refresh
) (
  input wire logic clk_i,                 // Processor bus clock
  input wire logic rst_n_i,               // Synchronous reset, active low
  input wire logic [31:0] ad_i,           // Multiplexed address and data
  input wire dbr_pkg::dbr_bus_t bus_i,    // Bus strobes
  input wire logic osc_tick_i,            // Oscillator tick, one cycle
  output dbr_pkg::dbr_mem_t mem_o,        // Memory array pins
  output logic ack_o,                     // Access done, one cycle
  output logic ref_ack_o                  // Refresh in progress
);
  import dbr_pkg::*;

  // ==========================================================
  // Address latch
  logic [31:0] addr_r, addr_nxt;          // Latched address phase
  logic pend_r, pend_nxt;                 // Address not yet served
  logic go;                               // Valid DRAM request waiting
  logic start;                            // Access begins this cycle
  logic [1:0] bank;                       // Selected bank
  logic [MA_W-1:0] row_a, col_a;          // Row and column halves

  // Capture the address phase, mark it unserved
  always_comb begin
    addr_nxt = addr_r;
    pend_nxt = pend_r & ~start;
    if (bus_i.ale) begin
      addr_nxt = ad_i;
      pend_nxt = 1'b1;                    // Set wins over clear
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      addr_r <= 32'h0;
      pend_r <= 1'b0;
    end else begin
      addr_r <= addr_nxt;
      pend_r <= pend_nxt;
    end
  end

  // Decode region, bank and address halves
  always_comb begin
    go = pend_r & (bus_i.rd | bus_i.wr)
       & (addr_r[31:REGION_LSB] == '0);
    bank = addr_r[BANK_LSB+1:BANK_LSB];
    row_a = addr_r[ROW_LSB+MA_W-1:ROW_LSB];
    col_a = addr_r[COL_LSB+MA_W-1:COL_LSB];
  end

  // ==========================================================
  // Refresh timer
  logic [15:0] tmr_r, tmr_nxt;            // Interval count
  logic req_r, req_nxt;                   // Refresh request
  logic ref_done;                         // Refresh finished this cycle
  logic tick;                             // Timer advances
  logic [15:0] tmr_top;                   // Last count of an interval

  // Count clock or oscillator, hold while request stands
  always_comb begin
    tick = USE_OSC ? osc_tick_i : 1'b1;
    tmr_top = USE_OSC ? 16'(OSC_REF_TICKS - 1) : 16'(REF_CYC - 1);
    tmr_nxt = tmr_r;
    req_nxt = req_r & ~ref_done;
    if (!req_r && !ref_ack_o && tick) begin
      if (tmr_r == tmr_top) begin
        tmr_nxt = 16'h0;
        req_nxt = 1'b1;
      end else begin
        tmr_nxt = tmr_r + 16'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tmr_r <= 16'h0;
      req_r <= 1'b0;
    end else begin
      tmr_r <= tmr_nxt;
      req_r <= req_nxt;
    end
  end

  // ==========================================================
  // Strobe state machine
  dbr_state_t st_r, st_nxt;               // Controller state
  logic [7:0] cnt_r, cnt_nxt;             // Cycles left in state
  dbr_mem_t mem_r, mem_nxt;               // Registered pins
  logic ack_nxt, rack_nxt;                // Registered answers
  logic [1:0] obank_r, obank_nxt;         // Bank of the open row
  logic [MA_W-1:0] orow_r, orow_nxt;      // Row left open
  logic wr_r, wr_nxt;                     // Current access is a write

  // Bank one-hot for strobes
  function automatic logic [3:0] sel_n(input logic [1:0] b);
    sel_n = ~(4'h1 << b);
  endfunction

  // Next state and pins
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = (cnt_r != 8'h0) ? cnt_r - 8'h1 : 8'h0;
    mem_nxt = mem_r;
    ack_nxt = 1'b0;
    rack_nxt = ref_ack_o;
    obank_nxt = obank_r;
    orow_nxt = orow_r;
    wr_nxt = wr_r;
    start = 1'b0;
    ref_done = 1'b0;
    case (st_r)
      S_IDLE: begin
        if (req_r) begin
          st_nxt = S_REF_COL;
          cnt_nxt = 8'(CSR_CYC - 1);
          mem_nxt.col_n = 4'h0;
          rack_nxt = 1'b1;
        end else if (go) begin
          start = 1'b1;
          st_nxt = S_ROW;
          cnt_nxt = 8'(RCD_CYC - 1);
          wr_nxt = bus_i.wr;
          mem_nxt.ma = row_a;
          mem_nxt.row_n = sel_n(bank);
          obank_nxt = bank;
          orow_nxt = row_a;
        end
      end
      S_ROW: begin
        if (cnt_r == 8'h0) begin
          st_nxt = S_COL;
          cnt_nxt = 8'(CAS_CYC - 1);
          mem_nxt.ma = col_a;
          // Reads take all lanes, writes only enabled lanes
          mem_nxt.col_n = wr_r ? ~bus_i.be : 4'h0;
          mem_nxt.we_n = wr_r ? sel_n(obank_r) : STROBES_OFF;
        end
      end
      S_COL: begin
        if (cnt_r == 8'h0) begin
          ack_nxt = 1'b1;
          mem_nxt.col_n = STROBES_OFF;
          mem_nxt.we_n = STROBES_OFF;
          if (wr_r) begin
            st_nxt = S_OPEN;              // Row stays open after a write
          end else begin
            st_nxt = S_PRE;
            cnt_nxt = 8'(RP_CYC - 1);
            mem_nxt.row_n = STROBES_OFF;
          end
        end
      end
      S_OPEN: begin
        // Refresh closes the row well inside the longest low time
        if (req_r || (go && !(bus_i.wr && bank == obank_r && row_a == orow_r))) begin
          st_nxt = S_PRE;
          cnt_nxt = 8'(RP_CYC - 1);
          mem_nxt.row_n = STROBES_OFF;
        end else if (go) begin
          start = 1'b1;                   // Page write
          wr_nxt = 1'b1;
          st_nxt = S_COL;
          cnt_nxt = 8'(CAS_CYC - 1);
          mem_nxt.ma = col_a;
          mem_nxt.col_n = ~bus_i.be;
          mem_nxt.we_n = sel_n(obank_r);
        end
      end
      S_REF_COL: begin
        if (cnt_r == 8'h0) begin
          st_nxt = S_REF_ROW;
          cnt_nxt = 8'(RAS_REF_CYC - 1);
          mem_nxt.row_n = 4'h0;
        end
      end
      S_REF_ROW: begin
        if (cnt_r == 8'h0) begin
          st_nxt = S_PRE;
          cnt_nxt = 8'(RP_CYC - 1);
          mem_nxt.row_n = STROBES_OFF;
          mem_nxt.col_n = STROBES_OFF;
          ref_done = 1'b1;
          rack_nxt = 1'b0;
        end
      end
      S_PRE: begin
        if (cnt_r == 8'h0) begin
          st_nxt = S_IDLE;
        end
      end
      default: begin
        st_nxt = S_PRE;
        mem_nxt = {STROBES_OFF, STROBES_OFF, STROBES_OFF, {MA_W{1'b0}}};
      end
    endcase
  end

  // Register state; reset starts with a refresh
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r <= S_REF_COL;
      cnt_r <= 8'(CSR_CYC - 1);
      mem_r <= {STROBES_OFF, 4'h0, STROBES_OFF, {MA_W{1'b0}}};
      ack_o <= 1'b0;
      ref_ack_o <= 1'b1;
      obank_r <= 2'h0;
      orow_r <= '0;
      wr_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      mem_r <= mem_nxt;
      ack_o <= ack_nxt;
      ref_ack_o <= rack_nxt;
      obank_r <= obank_nxt;
      orow_r <= orow_nxt;
      wr_r <= wr_nxt;
    end
  end

  assign mem_o = mem_r;

  // ==========================================================
  // Checks
  logic [15:0] low_cnt_r, low_cnt_nxt;    // Cycles any row strobe is low

  // Count consecutive cycles of a row strobe held low
  always_comb begin
    low_cnt_nxt = 16'h0;                  // All rows closed
    if (mem_r.row_n != STROBES_OFF) begin
      low_cnt_nxt = low_cnt_r + 16'h1;    // A row is still open
    end
  end

  // Register the low time count
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      low_cnt_r <= 16'h0;
    end else begin
      low_cnt_r <= low_cnt_nxt;
    end
  end

  a_ras_max_time: assert property (
    @(posedge clk_i) disable iff (!rst_n_i) low_cnt_r < 16'(RAS_MAX_CYC))
    else $error("row strobe low too long");

  a_one_bank_only: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (st_r != S_REF_ROW && !(st_r == S_PRE && $past(st_r) == S_REF_ROW))
      |-> $onehot0(~mem_r.row_n))
    else $error("more than one bank active");

  a_we_in_bank: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (~mem_r.we_n & mem_r.row_n) == 4'h0)
    else $error("write enable outside the open bank");

  a_bank_decode: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (st_r == S_ROW) |-> mem_r.row_n == sel_n(addr_r[BANK_LSB+1:BANK_LSB]))
    else $error("wrong bank selected");

  a_write_lanes: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (st_r == S_COL && $past(st_r) != S_COL && wr_r) |-> mem_r.col_n == ~$past(bus_i.be))
    else $error("write lanes do not follow byte enables");

  a_region_only: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(st_r == S_ROW) |-> $past(addr_r[31:REGION_LSB]) == '0)
    else $error("access outside DRAM region");

  a_cbr_order: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(st_r == S_REF_ROW) |-> mem_r.row_n == 4'h0 && $past(mem_r.col_n) == 4'h0)
    else $error("refresh not column before row");

  a_ref_period: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (!USE_OSC && $rose(req_r)) |-> $past(tmr_r) == 16'(REF_CYC - 1))
    else $error("refresh request at wrong count");

  a_reset_refresh: assert property (
    @(posedge clk_i) $rose(rst_n_i) |-> st_r == S_REF_COL && ref_ack_o)
    else $error("no refresh after reset");
endmodule

// [testbench/dbr_cpu_model.sv]
// Processor side bus model for the DRAM bank decode block.
// Assumes clk_i is the bus clock and ack_i a one cycle pulse.
`timescale 1ns/1ps
module dbr_cpu_model (
  input wire logic clk_i,           // Bus clock
  input wire logic ack_i,           // Access done pulse
  output dbr_pkg::dbr_bus_t bus_o,  // Bus strobes
  output logic [31:0] ad_o          // Address then data
);
  import dbr_pkg::*;
  // ==========================================================
  // Idle bus at time zero
  initial begin
    bus_o = '0;
    ad_o = 32'h0;
  end
  // ==========================================================
  // One access; gives up after 100 cycles without ack
  task automatic access(input logic [31:0] a, input logic w, input logic [3:0] be,
                        output bit ok);
    int n;
    ok = 1'b0;
    n = 0;
    @(posedge clk_i);
    bus_o.ale <= 1'b1;  // Address phase on shared lines
    ad_o <= a;
    @(posedge clk_i);
    bus_o.ale <= 1'b0;
    bus_o.rd <= !w;     // Strobe marks read or write
    bus_o.wr <= w;
    bus_o.be <= be;
    ad_o <= ~a;         // Data phase never repeats the address
    while (!ok && n < 100) begin
      @(negedge clk_i);
      ok = (ack_i === 1'b1);
      n++;
    end
    @(posedge clk_i);
    bus_o.rd <= 1'b0;   // Released the cycle after ack
    bus_o.wr <= 1'b0;
  endtask
endmodule

// [testbench/dbr_ctrl_tb.sv]
// Self-checking bench of the DRAM bank decode and refresh block.
// Assumes the processor model drives the bus and default parameters.
`timescale 1ns/1ps
module dbr_ctrl_tb;
  import dbr_pkg::*;
  // ==========================================================
  // Signals and bookkeeping
  logic clk = 1'b0;        // 200 MHz bus clock
  logic rst_n;             // Reset, active low
  logic osc_tick = 1'b0;   // Unused tick, kept toggling
  logic [31:0] ad;         // Shared address and data
  dbr_bus_t bus;           // Bus strobes
  dbr_mem_t mem;           // Memory pins
  logic ack;               // Access done
  logic ref_ack;           // Refresh busy
  int n_fail = 0;
  int n_compared = 0;
  logic [29:0] exp_q[$];   // Expected access pictures
  dbr_mem_t pm;            // Pins one cycle ago
  logic pr;                // Refresh busy one cycle ago
  logic [8:0] row_seen;    // Row address at row strobe fall
  logic [8:0] ma_seen;     // Column address at column fall
  logic [7:0] col_seen;    // Strobes at column fall
  logic [3:0] we_acc;      // Write enables seen in column phase
  int gap, low, n_ref = 0, started, i, n, n0;
  logic [31:0] a, r;
  logic [3:0] be;
  bit ok;
  always #2.5 clk = ~clk;
  dbr_ctrl dut (.clk_i(clk), .rst_n_i(rst_n), .ad_i(ad), .bus_i(bus),
    .osc_tick_i(osc_tick), .mem_o(mem), .ack_o(ack), .ref_ack_o(ref_ack));
  dbr_cpu_model cpu (.clk_i(clk), .ack_i(ack), .bus_o(bus), .ad_o(ad));
  // Ticks that the clock-counting timer must ignore
  always @(posedge clk) osc_tick <= ($urandom_range(0, 19) == 0);
  // ==========================================================
  // Compare and report
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Note the expected picture, then run the access
  task automatic go(input logic [31:0] ax, input logic w, input logic [3:0] bx);
    bit okx;
    logic [3:0] sel;
    sel = 4'h1 << ax[21:20];
    exp_q.push_back({~sel, w ? ~bx : 4'h0, w ? ~sel : 4'hF, ax[10:2], ax[19:11]});
    cpu.access(ax, w, bx, okx);
    chk("ack", 32'h1, {31'h0, okx});
  endtask
  // ==========================================================
  // Watcher: pictures each access, checks refresh and row time
  always @(negedge clk) begin
    if (rst_n !== 1'b1) begin
      gap = 0;
      low = 0;
      started = 0;
    end else begin
      if (ref_ack === 1'b0 && mem.row_n !== 4'hF && pm.row_n === 4'hF) row_seen = mem.ma;
      if (ref_ack === 1'b0 && mem.col_n !== 4'hF && pm.col_n === 4'hF) begin
        col_seen = {mem.row_n, mem.col_n};
        ma_seen = mem.ma;
        we_acc = 4'hF;
      end
      if (mem.col_n !== 4'hF) we_acc = we_acc & mem.we_n;
      if (ack === 1'b1) begin
        if (exp_q.size() == 0) chk("spare_ack", 32'h0, 32'h1);
        else chk("access", exp_q.pop_front(), {col_seen, we_acc, ma_seen, row_seen});
      end
      gap++;
      if (ref_ack === 1'b1 && pr === 1'b0) begin
        chk("ref_start", 32'hF0, {mem.row_n, mem.col_n});
        if (started) chk("ref_gap", 32'h1, gap >= REF_CYC && gap <= REF_CYC + 100);
        started = 1;
        gap = 0;
        n_ref++;
      end
      low = (mem.row_n !== 4'hF) ? low + 1 : 0;
      if (low == RAS_MAX_CYC + 1) chk("row_low", 32'h0, low);
    end
    pm = mem;
    pr = ref_ack;
  end
  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    void'($urandom(32'hC3CE));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("reset_ref", 32'h1F0, {ref_ack, mem.row_n, mem.col_n});
    n = 0;
    while (ref_ack !== 1'b0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk("reset_idle", 32'h0, {31'h0, ref_ack});
    $display("test reset done");
    // Reads then writes on every bank, each write followed by a page write
    for (i = 0; i < 8; i++) begin
      r = $urandom;
      a = {10'h000, i[1:0], r[17:0], 2'b00};
      be = 4'($urandom_range(1, 15));
      go(a, i[2], be);
      if (i[2]) go({a[31:11], r[26:18], 2'b00}, 1'b1, {be[2:0], 1'b1});
    end
    $display("test banks done");
    go(32'h000F_FFFC, 1'b0, 4'hF);
    go(32'h0010_0000, 1'b1, 4'h1);
    go(32'h003F_FFFC, 1'b0, 4'h3);
    cpu.access(32'h0040_0000, 1'b0, 4'hF, ok);
    chk("out_low", 32'h0, {31'h0, ok});
    cpu.access(32'h8000_0004, 1'b1, 4'hF, ok);
    chk("out_high", 32'h0, {31'h0, ok});
    $display("test region done");
    // Leave a row open and idle across several refreshes
    go(32'h0020_0010, 1'b1, 4'hC);
    n0 = n_ref;
    repeat (4500) @(posedge clk);
    chk("ref_count", 32'h1, n_ref - n0 >= 2);
    $display("test idle done");
    print_verdict;
  end
  // Watchdog well past the expected run
  initial begin
    #100000;
    n_fail++;
    print_verdict;
  end
endmodule
